// file: alu_consts.vh
/*
  opcode encodings, flag bit positions and cycle counts for the
  8-bit arithmetic and logic datapath. definitions only.
*/
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH
`define OP_W 5
`define OP_ADD 5'h00
`define OP_ADD_CARRY 5'h01
`define OP_WORD_IMMEDIATE_PLUS 5'h02
`define OP_SUB 5'h03
`define OP_DIFFERENCE_CONSTANT 5'h04
`define OP_DIFFERENCE_WITH_BORROW 5'h05
`define OP_DIFFERENCE_CONSTANT_BORROW 5'h06
`define OP_WORD_IMMEDIATE_MINUS 5'h07
`define OP_AND 5'h08
`define OP_CONJUNCTION_CONSTANT 5'h09
`define OP_OR 5'h0A
`define OP_UNION_CONSTANT 5'h0B
`define OP_XOR_REGISTERS 5'h0C
`define OP_ONES_INVERT 5'h0D
`define OP_TWOS_MINUS 5'h0E
`define OP_BITS_SET_MASK 5'h0F
`define OP_BITS_CLEAR_MASK 5'h10
`define OP_PLUS_ONE 5'h11
`define OP_MINUS_ONE 5'h12
`define OP_ZERO_SIGN_TEST 5'h13
// status flag positions in the 8-bit flag word
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RESET 8'h00
`define ALL_ONES 8'hFF
`define ALL_ZERO 8'h00
`define BYTE_ONE 8'h01
`define WORD_CYCLES 2
`endif

// file: alu_datapath.v
/*
  8-bit arithmetic and logic datapath with 16-bit word immediate
  add/subtract on register pairs. operands come from the register file
  and decoder; one request per clock that start is high while busy is low.
*/
`include "alu_consts.vh"
`timescale 1ns/10ps
module alu_datapath #(
  parameter W = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // request from decoder
  input wire start,
  input wire [`OP_W-1:0] op,
  input wire [W-1:0] dst_val,
  input wire [W-1:0] src_val,
  input wire [W-1:0] imm_val,
  input wire [W-1:0] dst_hi_val,
  // result to register file
  output reg [W-1:0] result_reg,
  output reg [W-1:0] result_hi_reg,
  output reg result_we_reg,
  output reg result_hi_we_reg,
  output reg [7:0] flags_reg,
  output reg busy_reg
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WORD_HI = 1'b1;
  reg state_reg;
  reg state_next;
  reg word_sub_reg;
  reg word_carry_reg;
  reg [W-1:0] word_hi_reg;
  reg [W-1:0] word_lo_reg;
  reg [W-1:0] a;
  reg [W-1:0] b;
  reg [W-1:0] r;
  reg cin;
  reg is_sub;
  reg arith;
  reg keep_c;
  reg logic_op;
  reg [W:0] sum;
  reg [W-1:0] res_next;
  reg [7:0] flags_next;
  reg we_next;
  wire f_z;
  wire f_n;
  wire f_v;
  wire f_s;
  wire f_h;
  wire c_in_flag;
  assign c_in_flag = flags_reg[`FLAG_C];

  always @* begin
    a = dst_val;
    b = src_val;
    cin = 1'b0;
    is_sub = 1'b0;
    arith = 1'b1;
    keep_c = 1'b0;
    logic_op = 1'b0;
    r = {W{1'b0}};
    we_next = start && !busy_reg;
    if (state_reg == ST_WORD_HI) begin
      // high byte: propagate low byte carry or borrow
      a = word_hi_reg;
      b = {W{1'b0}};
      cin = word_carry_reg;
      is_sub = word_sub_reg;
      we_next = 1'b0;
    end else begin
      case (op)
        `OP_ADD: b = src_val;
        `OP_ADD_CARRY: cin = c_in_flag;
        `OP_WORD_IMMEDIATE_PLUS: b = imm_val;
        `OP_SUB: is_sub = 1'b1;
        `OP_DIFFERENCE_CONSTANT: begin
          b = imm_val;
          is_sub = 1'b1;
        end
        `OP_DIFFERENCE_WITH_BORROW: begin
          is_sub = 1'b1;
          cin = c_in_flag;
        end
        `OP_DIFFERENCE_CONSTANT_BORROW: begin
          b = imm_val;
          is_sub = 1'b1;
          cin = c_in_flag;
        end
        `OP_WORD_IMMEDIATE_MINUS: begin
          b = imm_val;
          is_sub = 1'b1;
        end
        `OP_ONES_INVERT: begin
          a = `ALL_ONES;
          b = dst_val;
          is_sub = 1'b1;
        end
        `OP_TWOS_MINUS: begin
          a = `ALL_ZERO;
          b = dst_val;
          is_sub = 1'b1;
        end
        `OP_PLUS_ONE: begin
          b = `BYTE_ONE;
          keep_c = 1'b1;
        end
        `OP_MINUS_ONE: begin
          b = `BYTE_ONE;
          is_sub = 1'b1;
          keep_c = 1'b1;
        end
        `OP_AND, `OP_CONJUNCTION_CONSTANT, `OP_OR, `OP_UNION_CONSTANT,
        `OP_XOR_REGISTERS, `OP_BITS_SET_MASK, `OP_BITS_CLEAR_MASK,
        `OP_ZERO_SIGN_TEST: begin
          arith = 1'b0;
          logic_op = 1'b1;
        end
        default: begin
          arith = 1'b0;
          we_next = 1'b0;
        end
      endcase
    end
    sum = is_sub ? ({1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin})
                 : ({1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin});
    if (arith) begin
      r = sum[W-1:0];
    end else begin
      case (op)
        `OP_AND: r = dst_val & src_val;
        `OP_CONJUNCTION_CONSTANT: r = dst_val & imm_val;
        `OP_OR: r = dst_val | src_val;
        `OP_UNION_CONSTANT: r = dst_val | imm_val;
        `OP_XOR_REGISTERS: r = dst_val ^ src_val;
        `OP_BITS_SET_MASK: r = dst_val | imm_val;
        `OP_BITS_CLEAR_MASK: r = dst_val & (`ALL_ONES - imm_val);
        `OP_ZERO_SIGN_TEST: r = dst_val & dst_val;
        default: r = {W{1'b0}};
      endcase
    end
    res_next = r;
  end

  flag_calc #(
    .W(W)
  ) u_flags (
    .a(a),
    .b(b),
    .r(r),
    .is_sub(is_sub),
    .zero(f_z),
    .neg(f_n),
    .ovf(f_v),
    .sgn(f_s),
    .half(f_h)
  );

  always @* begin
    flags_next = flags_reg;
    state_next = state_reg;
    if (state_reg == ST_WORD_HI) begin
      // flags from the full 16-bit result
      flags_next[`FLAG_Z] = f_z && (word_lo_reg == {W{1'b0}});
      flags_next[`FLAG_N] = f_n;
      flags_next[`FLAG_V] = f_v;
      flags_next[`FLAG_S] = f_s;
      flags_next[`FLAG_C] = sum[W];
      state_next = ST_IDLE;
    end else if (we_next) begin
      // unknown opcodes leave every flag alone
      flags_next[`FLAG_Z] = f_z;
      flags_next[`FLAG_N] = f_n;
      if (logic_op) begin
        flags_next[`FLAG_V] = 1'b0;
      end else if (arith) begin
        flags_next[`FLAG_V] = f_v;
        if (!keep_c) begin
          flags_next[`FLAG_C] = sum[W];
        end
        if (op == `OP_ONES_INVERT) begin
          flags_next[`FLAG_C] = 1'b1;
          flags_next[`FLAG_V] = 1'b0;
        end
        if (op == `OP_WORD_IMMEDIATE_PLUS || op == `OP_WORD_IMMEDIATE_MINUS) begin
          state_next = ST_WORD_HI;
        end else if (!keep_c && op != `OP_ONES_INVERT) begin
          flags_next[`FLAG_H] = f_h;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      flags_reg <= `FLAGS_RESET;
      result_reg <= {W{1'b0}};
      result_hi_reg <= {W{1'b0}};
      result_we_reg <= 1'b0;
      result_hi_we_reg <= 1'b0;
      word_sub_reg <= 1'b0;
      word_carry_reg <= 1'b0;
      word_hi_reg <= {W{1'b0}};
      word_lo_reg <= {W{1'b0}};
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      busy_reg <= (state_next == ST_WORD_HI);
      result_hi_we_reg <= (state_reg == ST_WORD_HI);
      if (state_reg == ST_WORD_HI) begin
        result_hi_reg <= res_next;
        result_we_reg <= 1'b1;
        result_reg <= word_lo_reg;
      end else begin
        // word ops hold the low byte until both halves are ready
        result_we_reg <= we_next && (state_next != ST_WORD_HI);
        if (we_next) begin
          result_reg <= res_next;
        end
        word_lo_reg <= res_next;
        word_hi_reg <= dst_hi_val;
        word_sub_reg <= is_sub;
        word_carry_reg <= sum[W];
      end
    end
  end
endmodule // alu_datapath

// file: alu_datapath_asserts.sv
/* assertions on the alu_datapath ports.
   assumes one clock and a sync active-high reset; bound below. */
`timescale 1ns/10ps
module alu_datapath_asserts #(
  parameter W = 8
) (
  // clock and request
  input wire clk_sys,
  input wire sys_rst,
  input wire start,
  input wire [4:0] op,
  input wire [W-1:0] dst_val,
  input wire [W-1:0] src_val,
  // results
  input wire [W-1:0] result_reg,
  input wire result_we_reg,
  input wire result_hi_we_reg,
  input wire [7:0] flags_reg,
  input wire busy_reg
);
  wire take = start && !busy_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_byte_answer:
    assert property (take && op < 20 && op != 2 && op != 7 |=> result_we_reg)
    else $error("byte op gave no result");
  a_word_plus:
    assert property (take && op == 2 |=> busy_reg && !result_we_reg ##1 result_hi_we_reg)
    else $error("word plus timing wrong");
  a_word_minus:
    assert property (take && op == 7 |=> busy_reg ##1 !busy_reg && result_we_reg)
    else $error("word minus timing wrong");
  a_hi_with_low:
    assert property (result_hi_we_reg |-> result_we_reg)
    else $error("high byte without low byte");
  a_sub_value:
    assert property (take && op == 3 |=> result_reg == $past(dst_val) - $past(src_val))
    else $error("difference wrong");
  a_logic_v_clear:
    assert property (take && op inside {[8:12], 15, 16, 19} |=> !flags_reg[3])
    else $error("logic op left overflow set");
  a_step_keeps_carry:
    assert property (take && (op == 17 || op == 18) |=> $stable(flags_reg[0]))
    else $error("step op changed carry");
  a_ones_value:
    assert property (take && op == 13 |=> result_reg == ~$past(dst_val) && flags_reg[0])
    else $error("ones invert wrong");
  a_test_kept:
    assert property (take && op == 19 |=> result_reg == $past(dst_val))
    else $error("test changed value");
  a_xor_value:
    assert property (take && op == 12 |=> result_reg == ($past(dst_val) ^ $past(src_val)))
    else $error("xor wrong");
  c_word: cover property (take && op == 2);
  c_refused: cover property (start && busy_reg);
  c_ones: cover property (take && op == 13);
endmodule // alu_datapath_asserts
bind alu_datapath alu_datapath_asserts #(.W(W)) u_chk (.clk_sys, .sys_rst, .start, .op,
  .dst_val, .src_val, .result_reg, .result_we_reg, .result_hi_we_reg, .flags_reg, .busy_reg);

// file: alu_issue_model.sv
/* stand-in for decoder and register file: one request per call.
   assumes callers enter its tasks just after a rising clk_sys. */
`timescale 1ns/10ps
module alu_issue_model (
  // clock
  input wire clk_sys,
  // request
  output logic start = 1'b0,
  output logic [4:0] op = 5'h00,
  output logic [7:0] dst_val = 8'h00,
  output logic [7:0] src_val = 8'h00,
  output logic [7:0] imm_val = 8'h00,
  output logic [7:0] dst_hi_val = 8'h00
);
  // start left high so byte ops run back to back
  task issue(input logic [4:0] o, input logic [15:0] w, input logic [7:0] s,
      input logic [7:0] k);
    start = 1'b1;
    op = o;
    {dst_hi_val, dst_val} = w;
    src_val = s;
    imm_val = k;
    @(posedge clk_sys);
    #1;
  endtask
  // released operands scrambled, never held
  task idle();
    start = 1'b0;
    {dst_hi_val, dst_val, src_val, imm_val} = ~{dst_hi_val, dst_val, src_val, imm_val};
    @(posedge clk_sys);
    #1;
  endtask
endmodule // alu_issue_model

// file: eight_bit_alu_arith_logic_bench.sv
/* self-checking bench for alu_datapath, corner and random ops.
   assumes alu_issue_model drives requests; checker bound to the dut. */
`timescale 1ns/10ps
module eight_bit_alu_arith_logic_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  wire start, result_we_reg, result_hi_we_reg, busy_reg;
  wire [4:0] op;
  wire [7:0] dst_val, src_val, imm_val, dst_hi_val, result_reg, result_hi_reg, flags_reg;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] fx = 8'h00;
  logic [15:0] rx;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  alu_issue_model u_dec (.clk_sys, .start, .op, .dst_val, .src_val, .imm_val, .dst_hi_val);
  alu_datapath u_dut (.clk_sys, .sys_rst, .start, .op, .dst_val, .src_val, .imm_val,
    .dst_hi_val, .result_reg, .result_hi_reg, .result_we_reg, .result_hi_we_reg,
    .flags_reg, .busy_reg);
  // opcode numbers as encoded in alu_consts.vh
  function automatic void predict(input logic [4:0] o, input logic [15:0] w,
      input logic [7:0] s, input logic [7:0] k);
    logic [7:0] d, b, r;
    logic sb, cy, v;
    d = (o == 14) ? 8'h00 : w[7:0];
    b = (o inside {4, 6, 9, 11, 15, 16}) ? k : (o == 14) ? w[7:0] : s;
    sb = o inside {3, 4, 5, 6, 14};
    {cy, r} = sb ? d - b - ((o inside {5, 6}) & fx[0]) : d + b + ((o == 1) & fx[0]);
    if (o inside {0, 1, 3, 4, 5, 6, 14}) fx[5] = d[4] ^ b[4] ^ r[4];
    v = (d[7] ^ b[7] ^ !sb) & (r[7] ^ d[7]);
    case (o)
      8, 9, 19: r = d & ((o == 19) ? d : b);
      16: r = d & (8'hFF - k);
      10, 11, 15: r = d | b;
      12: r = d ^ s;
      13: r = 8'hFF - d;
      17: r = d + 8'h01;
      18: r = d - 8'h01;
      default: ;
    endcase
    v = (o == 17) ? r == 8'h80 : (o == 18) ? r == 8'h7F : (o > 7 && o != 14) ? 1'b0 : v;
    rx = {r, r};
    if (o == 2 || o == 7) begin
      {cy, rx} = (o == 7) ? w - k : w + k;
      v = (w[15] ^ rx[15]) & (rx[15] ^ (o == 7));
      fx[4] = rx[15] ^ v;
    end
    if (o < 8 || o inside {13, 14}) fx[0] = (o == 13) | cy;
    fx[1] = rx == 16'h0000;
    fx[2] = rx[15];
    fx[3] = v;
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task run(input logic [4:0] o, input logic [15:0] w, input logic [7:0] s, input logic [7:0] k);
    predict(o, w, s, k);
    u_dec.issue(o, w, s, k);
    if (o == 2 || o == 7) begin
      chk({busy_reg, result_we_reg}, 16'h0002);
      // second request lands while busy and must be ignored
      u_dec.issue(5'h11, 16'h0000, s, k);
      chk({result_hi_reg, result_reg}, rx);
      chk({busy_reg, result_hi_we_reg, result_we_reg}, 16'h0003);
      chk(flags_reg, fx);
      u_dec.idle();
      chk(result_we_reg, 1'b0);
    end else begin
      chk({result_hi_we_reg, busy_reg, result_we_reg, result_reg}, {3'b001, rx[7:0]});
      chk(flags_reg, fx);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // about 520 cycles of traffic expected
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h7369_b410));
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    chk({busy_reg, result_we_reg, flags_reg}, 16'h0000);
    run(5'h00, 16'h00FF, 8'h01, 8'h00);
    run(5'h01, 16'h007F, 8'h00, 8'h00);
    run(5'h06, 16'h0000, 8'h00, 8'h00);
    run(5'h05, 16'h0010, 8'h10, 8'h00);
    run(5'h02, 16'hFFFF, 8'h00, 8'h01);
    run(5'h07, 16'h8000, 8'h00, 8'h01);
    run(5'h0E, 16'h0080, 8'h00, 8'h00);
    run(5'h12, 16'h0080, 8'h00, 8'h00);
    run(5'h10, 16'h00FF, 8'h00, 8'hF0);
    // undefined opcode must be ignored: no result, flags kept
    u_dec.issue(5'h1F, 16'($urandom), 8'($urandom), 8'($urandom));
    chk(result_we_reg, 1'b0);
    chk({result_reg, flags_reg}, {rx[7:0], fx});
    $display("corner ops done");
    for (int o = 0; o < 20; o++)
      run(5'(o), 16'($urandom), 8'($urandom), 8'($urandom));
    $display("every opcode done");
    for (int i = 0; i < 400; i++)
      run(5'($urandom % 20), 16'($urandom), 8'($urandom), 8'($urandom));
    $display("random ops done");
    stop_test();
  end
endmodule // eight_bit_alu_arith_logic_bench

// file: flag_calc.v
/*
  combinational flag helper: zero, negative, overflow, sign and
  half-carry for an 8-bit add or subtract result.
  assumes the result r already includes any carry-in choice by the caller.
*/
`timescale 1ns/10ps
module flag_calc #(
  parameter W = 8
) (
  // operands and result
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire [W-1:0] r,
  input wire is_sub,
  // flags
  output wire zero,
  output wire neg,
  output wire ovf,
  output wire sgn,
  output wire half
);
  assign zero = (r == {W{1'b0}});
  assign neg = r[W-1];
  // add: same-sign operands give opposite result; sub: signs differ
  assign ovf = is_sub ? ((a[W-1] & ~b[W-1] & ~r[W-1]) | (~a[W-1] & b[W-1] & r[W-1]))
                      : ((a[W-1] & b[W-1] & ~r[W-1]) | (~a[W-1] & ~b[W-1] & r[W-1]));
  assign sgn = neg ^ ovf;
  assign half = is_sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
                       : ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
endmodule // flag_calc
